// [logic/mpr_field_decode.sv]
`timescale 1ns/100ps
module mpr_field_decode
  import mpr_pkg::*;
#(
  parameter int unsigned PIN = 0
) (
  input  wire logic      [3:0] code,
  output      mpr_func_e       func,
  output      logic      [3:0] irqNum
);

  always_comb begin
    func   = MPR_MAP[PIN][code];
    irqNum = code;
    if (PIN == MPR_ALT_IRQ_PIN && code == MPR_ALT_IRQ_CODE) begin
      irqNum = MPR_ALT_IRQ_NUM;
    end
  end

endmodule

// [logic/mpr_pkg.sv]
// Operation
// - Routing bits 31-28 always read zero; writes to them are dropped.
// - Terminal 6 field: 0 reserved (default), 1 clock run, 2-15 pick IRQ2-IRQ15.
// - Terminal 5 field selects from its sixteen-entry table; code 0 is general input.
// - Terminal 4 codes 12-15 pick ring output, socket LED, event, power flag.
// - Serial bus mode (latch low) makes terminal 1 data, terminal 4 clock.
// - Terminal 3 field: 0 reserved, 1 serialized IRQ (default), 2-15 IRQ2-IRQ15.
// - Terminal 2 field selects from its sixteen-entry table; code 0 is general input.
// - Terminal 1 field selects from its table; code 2 is INTB.
// - Terminal 0 field selects from its table; code 2 is INTA.
// - Reset value of the routing register is 0000_1000h.
// - A serial EEPROM may load the routing register in place of the reset value.
// - Ring output reaches a terminal only while the ring enable bit is set.
// - Card audio goes to audio terminals when enabled; socket 0 wins over 1.
package mpr_pkg;

  localparam int unsigned MPR_NUM_PINS   = 7;
  localparam int unsigned MPR_FIELD_W    = 4;
  localparam int unsigned MPR_ROUTE_W    = 28;
  localparam int unsigned MPR_RSVD_LSB   = 28;
  localparam logic [7:0]  MPR_ROUTE_ADDR = 8'h8c;
  localparam logic [31:0] MPR_ROUTE_RST  = 32'h00001000;
  localparam int unsigned MPR_FIELD_LSB [MPR_NUM_PINS] = '{0, 4, 8, 12, 16, 20, 24};
  localparam int unsigned MPR_SDA_PIN    = 1;
  localparam int unsigned MPR_SCL_PIN    = 4;
  localparam int unsigned MPR_ALT_IRQ_PIN = 2;
  localparam logic [3:0]  MPR_ALT_IRQ_CODE = 4'hf;
  localparam logic [3:0]  MPR_ALT_IRQ_NUM  = 4'h7;

  typedef enum logic [4:0] {
    F_RSVD   = 5'b00000,
    F_GPI    = 5'b00001,
    F_GPO    = 5'b00010,
    F_IRQ    = 5'b00011,
    F_CLKRUN = 5'b00100,
    F_SERIRQ = 5'b00101,
    F_INTA   = 5'b00110,
    F_INTB   = 5'b00111,
    F_DREQ   = 5'b01000,
    F_DGNT   = 5'b01001,
    F_VSTAT  = 5'b01010,
    F_VSEL0  = 5'b01011,
    F_VSEL1  = 5'b01100,
    F_AUDIO  = 5'b01101,
    F_D3     = 5'b01110,
    F_LED1   = 5'b01111,
    F_LED2   = 5'b10000,
    F_LEDSKT = 5'b10001,
    F_GPE    = 5'b10010,
    F_RIOUT  = 5'b10011
  } mpr_func_e;

  // Index is the field code; IRQ entries take their number from the code, except terminal 2 code 15 (IRQ7)
  localparam mpr_func_e MPR_MAP [MPR_NUM_PINS][16] = '{
    '{F_GPI, F_GPO, F_INTA, F_IRQ, F_IRQ, F_IRQ, F_VSTAT, F_VSEL0,
      F_AUDIO, F_IRQ, F_IRQ, F_IRQ, F_LED1, F_LED2, F_GPE, F_IRQ},
    '{F_GPI, F_GPO, F_INTB, F_IRQ, F_IRQ, F_IRQ, F_VSTAT, F_VSEL0,
      F_AUDIO, F_IRQ, F_IRQ, F_IRQ, F_LED1, F_LED2, F_GPE, F_IRQ},
    '{F_GPI, F_GPO, F_DREQ, F_IRQ, F_IRQ, F_IRQ, F_VSTAT, F_VSEL0,
      F_AUDIO, F_IRQ, F_IRQ, F_D3, F_RIOUT, F_LED2, F_GPE, F_IRQ},
    '{F_RSVD, F_SERIRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ,
      F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ},
    '{F_GPI, F_RSVD, F_RSVD, F_RSVD, F_RSVD, F_RSVD, F_RSVD, F_RSVD,
      F_RSVD, F_RSVD, F_RSVD, F_RSVD, F_RIOUT, F_LEDSKT, F_GPE, F_D3},
    '{F_GPI, F_GPO, F_DGNT, F_IRQ, F_IRQ, F_IRQ, F_VSTAT, F_VSEL1,
      F_AUDIO, F_D3, F_IRQ, F_IRQ, F_LED1, F_LEDSKT, F_GPE, F_IRQ},
    '{F_RSVD, F_CLKRUN, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ,
      F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ, F_IRQ}
  };

endpackage

// [logic/mpr_router.sv]
`timescale 1ns/100ps
module mpr_router
  import mpr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output      logic [31:0] cfgRdData,
  input  wire logic        eepromLoadValid,
  input  wire logic [31:0] eepromLoadData,
  input  wire logic        serialBusModeN,
  input  wire logic        sdaDriveLow,
  input  wire logic        sclDriveLow,
  input  wire logic [15:0] irqRequest,
  input  wire logic        clkRunDriveLow,
  input  wire logic        serIrqOut,
  input  wire logic        serIrqOe,
  input  wire logic        intaAssert,
  input  wire logic        intbAssert,
  input  wire logic        dmaRequest,
  input  wire logic        videoPortStatus,
  input  wire logic        videoPortSelect0,
  input  wire logic        videoPortSelect1,
  input  wire logic [1:0]  cardAudioSignal,
  input  wire logic [1:0]  audioToPinEnable,
  input  wire logic        lowPowerStateFlag,
  input  wire logic        activityLed1,
  input  wire logic        activityLed2,
  input  wire logic        socketActivityLed,
  input  wire logic        generalEventOut,
  input  wire logic        ringIndicateOutput,
  input  wire logic        ringOutputEnable,
  input  wire logic [6:0]  generalOutput,
  input  wire logic [6:0]  sharedPinIn,
  output      logic [6:0]  sharedPinOut,
  output      logic [6:0]  sharedPinOe,
  output      logic [6:0]  generalInput,
  output      logic        dmaGrant,
  output      logic        clkRunIn,
  output      logic        serIrqIn,
  output      logic        sdaIn,
  output      logic        serialModeActive,
  output      logic [31:0] routeValue
);

  typedef struct packed {
    logic [MPR_ROUTE_W-1:0] route;
    logic [31:0]            rdData;
    logic [6:0]             pinOut;
    logic [6:0]             pinOe;
    logic [6:0]             gpIn;
    logic                   dmaGrant;
    logic                   clkRunIn;
    logic                   serIrqIn;
    logic                   sdaIn;
    logic                   serialMode;
  } mpr_state_s;

  localparam mpr_state_s MPR_STATE_RST = '{
    route:      MPR_ROUTE_RST[MPR_ROUTE_W-1:0],
    rdData:     '0,
    pinOut:     '0,
    pinOe:      '0,
    gpIn:       '0,
    dmaGrant:   1'b0,
    clkRunIn:   1'b0,
    serIrqIn:   1'b0,
    sdaIn:      1'b0,
    serialMode: 1'b0
  };

  mpr_state_s state_q;
  mpr_state_s state_d;

  logic [6:0] drvOut;
  logic [6:0] drvOe;
  logic [6:0] hitGpi;
  logic [6:0] hitGnt;
  logic [6:0] hitClk;
  logic [6:0] hitSer;
  logic [6:0] hitSda;
  logic       audioLevel;
  logic       routeHit;
  logic [31:0] routeWord;

  // Socket 0 takes the audio terminal when both sockets ask for it
  always_comb begin
    if (audioToPinEnable[0]) begin
      audioLevel = cardAudioSignal[0];
    end else if (audioToPinEnable[1]) begin
      audioLevel = cardAudioSignal[1];
    end else begin
      audioLevel = 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < MPR_NUM_PINS; gi++) begin : g_pin
      mpr_func_e  func;
      logic [3:0] irqNum;

      mpr_field_decode #(
        .PIN (gi)
      ) u_decode (
        .code   (state_q.route[MPR_FIELD_LSB[gi] +: MPR_FIELD_W]),
        .func   (func),
        .irqNum (irqNum)
      );

      always_comb begin
        drvOut[gi] = 1'b0;
        drvOe[gi]  = 1'b0;
        hitGpi[gi] = 1'b0;
        hitGnt[gi] = 1'b0;
        hitClk[gi] = 1'b0;
        hitSer[gi] = 1'b0;
        hitSda[gi] = 1'b0;
        // Serial bus strap overrides the routing field for the two bus terminals
        if (state_q.serialMode && gi == MPR_SDA_PIN) begin
          drvOe[gi]  = sdaDriveLow;
          hitSda[gi] = 1'b1;
        end else if (state_q.serialMode && gi == MPR_SCL_PIN) begin
          drvOe[gi]  = sclDriveLow;
        end else begin
          case (func)
            F_GPI: begin
              hitGpi[gi] = 1'b1;
            end
            F_GPO: begin
              drvOut[gi] = generalOutput[gi];
              drvOe[gi]  = 1'b1;
            end
            F_IRQ: begin
              drvOut[gi] = irqRequest[irqNum];
              drvOe[gi]  = 1'b1;
            end
            F_CLKRUN: begin
              drvOe[gi]  = clkRunDriveLow;
              hitClk[gi] = 1'b1;
            end
            F_SERIRQ: begin
              drvOut[gi] = serIrqOut;
              drvOe[gi]  = serIrqOe;
              hitSer[gi] = 1'b1;
            end
            F_INTA: begin
              drvOe[gi]  = intaAssert;
            end
            F_INTB: begin
              drvOe[gi]  = intbAssert;
            end
            F_DREQ: begin
              drvOut[gi] = dmaRequest;
              drvOe[gi]  = 1'b1;
            end
            F_DGNT: begin
              hitGnt[gi] = 1'b1;
            end
            F_VSTAT: begin
              drvOut[gi] = videoPortStatus;
              drvOe[gi]  = 1'b1;
            end
            F_VSEL0: begin
              drvOut[gi] = videoPortSelect0;
              drvOe[gi]  = 1'b1;
            end
            F_VSEL1: begin
              drvOut[gi] = videoPortSelect1;
              drvOe[gi]  = 1'b1;
            end
            F_AUDIO: begin
              drvOut[gi] = audioLevel;
              drvOe[gi]  = 1'b1;
            end
            F_D3: begin
              drvOut[gi] = lowPowerStateFlag;
              drvOe[gi]  = 1'b1;
            end
            F_LED1: begin
              drvOut[gi] = activityLed1;
              drvOe[gi]  = 1'b1;
            end
            F_LED2: begin
              drvOut[gi] = activityLed2;
              drvOe[gi]  = 1'b1;
            end
            F_LEDSKT: begin
              drvOut[gi] = socketActivityLed;
              drvOe[gi]  = 1'b1;
            end
            F_GPE: begin
              drvOut[gi] = generalEventOut;
              drvOe[gi]  = 1'b1;
            end
            F_RIOUT: begin
              // Floats while disabled so the board pull keeps the line idle
              drvOut[gi] = ringIndicateOutput;
              drvOe[gi]  = ringOutputEnable;
            end
            default: begin
              drvOe[gi]  = 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  assign routeWord = {{(32 - MPR_ROUTE_W){1'b0}}, state_q.route};
  assign routeHit  = (cfgAddr[7:2] == MPR_ROUTE_ADDR[7:2]);

  always_comb begin
    logic [31:0] wordNext;
    wordNext = routeWord;
    state_d  = state_q;
    // EEPROM load first, so a host write in the same cycle still lands on top
    if (eepromLoadValid) begin
      wordNext = eepromLoadData;
    end
    if (cfgWrite && routeHit) begin
      for (int b = 0; b < 4; b++) begin
        if (cfgByteEn[b]) begin
          wordNext[8*b +: 8] = cfgWrData[8*b +: 8];
        end
      end
    end
    state_d.route = wordNext[MPR_ROUTE_W-1:0];
    if (cfgRead) begin
      state_d.rdData = routeHit ? routeWord : 32'h00000000;
    end
    state_d.serialMode = ~serialBusModeN;
    state_d.pinOut     = drvOut;
    state_d.pinOe      = drvOe;
    state_d.gpIn       = hitGpi & sharedPinIn;
    state_d.dmaGrant   = |(hitGnt & sharedPinIn);
    state_d.clkRunIn   = |(hitClk & sharedPinIn);
    state_d.serIrqIn   = |(hitSer & sharedPinIn);
    state_d.sdaIn      = |(hitSda & sharedPinIn);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= MPR_STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign cfgRdData        = state_q.rdData;
  assign sharedPinOut     = state_q.pinOut;
  assign sharedPinOe      = state_q.pinOe;
  assign generalInput     = state_q.gpIn;
  assign dmaGrant         = state_q.dmaGrant;
  assign clkRunIn         = state_q.clkRunIn;
  assign serIrqIn         = state_q.serIrqIn;
  assign sdaIn            = state_q.sdaIn;
  assign serialModeActive = state_q.serialMode;
  assign routeValue       = routeWord;

endmodule

// [tb/mpr_board.sv]
`timescale 1ns/100ps
module mpr_board (
  input  wire logic [6:0] pinOut,
  input  wire logic [6:0] pinOe,
  input  wire logic [6:0] extLevel,
  output      logic [6:0] pinIn
);
  // A released terminal shows the board level, never the last driven value
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extLevel[i];
    end
  end
endmodule

// [tb/mpr_router_sva.sv]
`timescale 1ns/100ps
module mpr_router_sva (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [7:0]  cfgAddr,
  input wire logic        cfgWrite,
  input wire logic        cfgRead,
  input wire logic [3:0]  cfgByteEn,
  input wire logic [31:0] cfgWrData,
  input wire logic [31:0] cfgRdData,
  input wire logic        eepromLoadValid,
  input wire logic [31:0] eepromLoadData,
  input wire logic        serialBusModeN,
  input wire logic        sclDriveLow,
  input wire logic [15:0] irqRequest,
  input wire logic        clkRunDriveLow,
  input wire logic [1:0]  cardAudioSignal,
  input wire logic [1:0]  audioToPinEnable,
  input wire logic        ringOutputEnable,
  input wire logic [6:0]  sharedPinIn,
  input wire logic [6:0]  sharedPinOut,
  input wire logic [6:0]  sharedPinOe,
  input wire logic [6:0]  generalInput,
  input wire logic [31:0] routeValue
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  reset_value_a: assert property ($fell(reset) |-> routeValue == 32'h00001000)
    else $error("routing not at reset value");
  write_lands_a: assert property (cfgWrite && cfgAddr == 8'h8c && cfgByteEn == 4'hf
    |=> routeValue == {4'h0, $past(cfgWrData[27:0])}) else $error("write not stored");
  read_back_a: assert property (cfgRead && cfgAddr == 8'h8c |=> cfgRdData == $past(routeValue))
    else $error("read data wrong");
  eeprom_load_a: assert property (eepromLoadValid && !cfgWrite
    |=> routeValue == {4'h0, $past(eepromLoadData[27:0])}) else $error("load not stored");
  irq_drive_a: assert property (routeValue[3:0] == 4'h3
    |=> sharedPinOe[0] && sharedPinOut[0] == $past(irqRequest[3])) else $error("irq3 not driven");
  input_float_a: assert property (routeValue[3:0] == 4'h0
    |=> !sharedPinOe[0] && generalInput[0] == $past(sharedPinIn[0])) else $error("input not sampled");
  ring_gate_a: assert property (routeValue[11:8] == 4'hc |=> sharedPinOe[2] == $past(ringOutputEnable))
    else $error("ring gate wrong");
  clock_run_a: assert property (routeValue[27:24] == 4'h1
    |=> !sharedPinOut[6] && sharedPinOe[6] == $past(clkRunDriveLow)) else $error("clock run wrong");
  audio_first_a: assert property (routeValue[23:20] == 4'h8 && audioToPinEnable[0]
    |=> sharedPinOut[5] == $past(cardAudioSignal[0])) else $error("audio source wrong");
  serial_clock_a: assert property ((!serialBusModeN && sclDriveLow) [*2]
    |=> sharedPinOe[4] && !sharedPinOut[4]) else $error("serial clock not driven");
endmodule

bind mpr_router mpr_router_sva i_sva (.*);

// [tb/mpr_router_tb_top.sv]
`timescale 1ns/100ps
module mpr_router_tb_top;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  cfgAddr = 8'h0;
  logic        cfgWrite = 1'b0;
  logic        cfgRead = 1'b0;
  logic [3:0]  cfgByteEn = 4'h0;
  logic [31:0] cfgWrData = 32'h0;
  logic        eeLoad = 1'b0;
  logic [31:0] eeData = 32'h0;
  logic        busModeN = 1'b1;
  logic [31:0] rv = 32'h0;
  logic [19:0] rw = 20'h0;
  logic [31:0] rdData, routeVal, cur;
  logic [6:0]  pinIn, pinOut, pinOe, genIn;
  logic        sdaIn;
  logic        dmaGrant, clkRunIn, serIrqIn, serMode;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          irqTab [9][2] = '{'{0, 3}, '{0, 9}, '{0, 15}, '{1, 11}, '{1, 15}, '{2, 15}, '{2, 4}, '{5, 10}, '{5, 15}};
  // Pin, code, kind of function the rules give that code
  int          fnTab [24][3] = '{'{0, 0, 16}, '{0, 1, 1}, '{0, 2, 2}, '{0, 6, 5}, '{0, 7, 6}, '{0, 8, 8},
    '{0, 12, 10}, '{0, 14, 12}, '{1, 1, 1}, '{1, 2, 3}, '{1, 8, 8}, '{1, 13, 11}, '{2, 2, 4}, '{2, 11, 9},
    '{3, 0, 0}, '{3, 1, 13}, '{4, 0, 16}, '{4, 5, 0}, '{5, 2, 17}, '{5, 7, 7}, '{5, 9, 9}, '{5, 13, 15},
    '{6, 0, 0}, '{6, 1, 14}};

  always #4 mclk = ~mclk;

  mpr_router i_dut (
    .mclk(mclk), .reset(reset), .cfgAddr(cfgAddr), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(rdData), .eepromLoadValid(eeLoad),
    .eepromLoadData(eeData), .serialBusModeN(busModeN), .sdaDriveLow(rw[4]), .sclDriveLow(rw[5]),
    .irqRequest(rv[15:0]), .clkRunDriveLow(rv[16]), .serIrqOut(rv[17]), .serIrqOe(rv[18]),
    .intaAssert(rv[19]), .intbAssert(rv[20]), .dmaRequest(rv[21]), .videoPortStatus(rv[22]),
    .videoPortSelect0(rv[23]), .videoPortSelect1(rv[24]), .cardAudioSignal(rv[26:25]),
    .audioToPinEnable(rv[28:27]), .lowPowerStateFlag(rv[29]), .activityLed1(rv[30]),
    .activityLed2(rv[31]), .socketActivityLed(rw[0]), .generalEventOut(rw[1]),
    .ringIndicateOutput(rw[2]), .ringOutputEnable(rw[3]), .generalOutput(rw[12:6]),
    .sharedPinIn(pinIn), .sharedPinOut(pinOut), .sharedPinOe(pinOe), .generalInput(genIn),
    .dmaGrant(dmaGrant), .clkRunIn(clkRunIn), .serIrqIn(serIrqIn), .sdaIn(sdaIn), .serialModeActive(serMode),
    .routeValue(routeVal)
  );
  mpr_board i_board (.pinOut(pinOut), .pinOe(pinOe), .extLevel(rw[19:13]), .pinIn(pinIn));

  function automatic int irq_of(input int p, input int c);
    return (p == 2 && c == 15) ? 7 : c;
  endfunction

  function automatic logic [31:0] one_field(input int p, input int c);
    return (32'h00001000 & ~(32'hf << (4 * p))) | (32'(c) << (4 * p));
  endfunction

  // Drive enable and gated drive level of a terminal for each kind of function
  function automatic logic [1:0] fn_exp(input int p, input int k);
    logic aud;
    aud = rv[27] ? rv[25] : (rv[28] & rv[26]);
    case (k)
      1: return {1'b1, rw[6 + p]};
      2: return {rv[19], 1'b0};
      3: return {rv[20], 1'b0};
      4: return {1'b1, rv[21]};
      5: return {1'b1, rv[22]};
      6: return {1'b1, rv[23]};
      7: return {1'b1, rv[24]};
      8: return {1'b1, aud};
      9: return {1'b1, rv[29]};
      10: return {1'b1, rv[30]};
      11: return {1'b1, rv[31]};
      12: return {1'b1, rw[1]};
      13: return {rv[18], rv[17] & rv[18]};
      14: return {rv[16], 1'b0};
      15: return {1'b1, rw[0]};
      default: return 2'b00;
    endcase
  endfunction

  // Sampled inputs; terminal 3 keeps serialized IRQ unless it is the one rerouted
  function automatic logic [3:0] in_exp(input int p, input int k);
    logic ser;
    ser = rv[18] ? rv[17] : rw[16];
    return {(k == 16) & rw[13 + p], (k == 17) & rw[18], (k == 14) & ~rv[16] & rw[19],
            ((p != 3) | (k == 13)) & ser};
  endfunction

  function automatic logic [1:0] t4_exp(input int c);
    case (c)
      12: return {rw[3], rw[2] & rw[3]};
      13: return {1'b1, rw[0]};
      14: return {1'b1, rw[1]};
      default: return {1'b1, rv[29]};
    endcase
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    cfgAddr = a;
    cfgWrData = d;
    cfgByteEn = be;
    cfgWrite = 1'b1;
    @(negedge mclk);
    cfgWrite = 1'b0;
    @(negedge mclk);
  endtask

  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge mclk);
    cfgRead = 1'b0;
    check(rdData, exp);
    @(negedge mclk);
  endtask

  // Other fields stay at reset codes so only one terminal changes
  task automatic map_irq(input int p, input int c);
    cfg_wr(8'h8c, one_field(p, c), 4'hf);
    rv = $urandom;
    @(negedge mclk);
    check({pinOe[p], pinOut[p]}, {1'b1, rv[irq_of(p, c)]});
  endtask

  task automatic map_fn(input int p, input int c, input int k);
    cfg_wr(8'h8c, one_field(p, c), 4'hf);
    rv = $urandom;
    rw = 20'($urandom);
    repeat (2) @(negedge mclk);
    check({pinOe[p], pinOut[p] & pinOe[p]}, fn_exp(p, k));
    check({genIn[p], dmaGrant, clkRunIn, serIrqIn}, in_exp(p, k));
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    rv = $urandom(6490);
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    cfg_rd(8'h8c, 32'h00001000);
    rw = 20'($urandom);
    repeat (2) @(negedge mclk);
    check({pinOe[0], genIn[0]}, {1'b0, rw[13]});
    cfg_wr(8'h8c, 32'hffffffff, 4'hf);
    cfg_wr(8'h90, 32'h12345678, 4'hf);
    cfg_rd(8'h8c, 32'h0fffffff);
    cfg_rd(8'h90, 32'h0);
    for (int c = 2; c < 16; c++) begin
      map_irq(6, c);
      map_irq(3, c);
    end
    foreach (irqTab[i]) map_irq(irqTab[i][0], irqTab[i][1]);
    foreach (fnTab[i]) map_fn(fnTab[i][0], fnTab[i][1], fnTab[i][2]);
    for (int c = 12; c < 16; c++) begin
      cfg_wr(8'h8c, one_field(4, c), 4'hf);
      rw = 20'($urandom);
      rv = $urandom;
      @(negedge mclk);
      check({pinOe[4], pinOut[4] & pinOe[4]}, t4_exp(c));
    end
    busModeN = 1'b0;
    rw = 20'h04020;
    repeat (3) @(negedge mclk);
    check({pinOe[4], pinOut[4], pinOe[1], sdaIn, serMode}, 5'b10011);
    busModeN = 1'b1;
    eeData = $urandom;
    eeLoad = 1'b1;
    @(negedge mclk);
    eeLoad = 1'b0;
    cur = {4'h0, eeData[27:0]};
    check(routeVal, cur);
    cfg_rd(8'h8c, cur);
    rv = $urandom;
    cfg_wr(8'h8c, rv, 4'h5);
    cur = ((cur & 32'hff00ff00) | (rv & 32'h00ff00ff)) & 32'h0fffffff;
    cfg_rd(8'h8c, cur);
    // Random traffic keeps ring, audio and clock-run routings live for the checker
    for (int i = 0; i < 30; i++) begin
      cfg_wr(8'h8c, ($urandom & 32'hf00f00ff) | 32'h01800c00, 4'hf);
      repeat (6) begin
        rv = $urandom;
        rw = 20'($urandom);
        busModeN = 1'($urandom);
        @(negedge mclk);
      end
    end
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    check({pinOe, pinOut, genIn, dmaGrant, clkRunIn, serIrqIn, sdaIn, serMode}, 32'h0);
    check(rdData, 32'h0);
    reset = 1'b0;
    @(negedge mclk);
    cfg_rd(8'h8c, 32'h00001000);
    report_and_stop();
  end
endmodule
